// [rtl/scp_pkg.sv]
// shared constants for the serial port control block
package scp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;

  // control register one: width, writable bits, reset value
  localparam int CTRL1_W = 16;
  localparam logic [15:0] CTRL1_WMASK = 16'h1FFF;
  localparam logic [15:0] CTRL1_RST = 16'h0000;
  localparam int CFG_W = 13;

  // control register one field positions
  localparam int B_CLK_DIS = 12;
  localparam int B_DO_DIS = 11;
  localparam int B_WIDTH = 10;
  localparam int B_SMP = 9;
  localparam int B_EDGE = 8;
  localparam int B_SLAVE_SELECT_ENABLE = 7;
  localparam int B_CPOL = 6;
  localparam int B_MST = 5;
  localparam int B_SEC_LSB = 2;
  localparam int B_PRI_LSB = 0;

  // status register field positions
  localparam int B_STAT_BUSY = 0;
  localparam int B_STAT_RXV = 1;

  // word and byte transfer lengths in bits
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;

  // reset values of the data words
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // bus transfer type that starts a transfer
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // divider width and prescale ratio lookup
  localparam int DIV_W = 10;

  function automatic logic [9:0] primary_ratio(input logic [1:0] code);
    unique case (code)
      2'h3: primary_ratio = 10'h001;
      2'h2: primary_ratio = 10'h004;
      2'h1: primary_ratio = 10'h010;
      2'h0: primary_ratio = 10'h040;
    endcase
  endfunction : primary_ratio

  function automatic logic [9:0] secondary_ratio(input logic [2:0] code);
    secondary_ratio = 10'h008 - {7'h00, code};
  endfunction : secondary_ratio

endpackage : scp_pkg

// [rtl/scp_port.sv]
// serial port control block: bus registers and link-side serial engine
//
// Contract
// - master with clock-pin disable stops internal clock, releases clock pin
// - data-out disable releases data-out pin; clear means module drives it, except a slave deselected with select enabled
// - width select set gives 16-bit words, clear gives 8-bit bytes
// - master sample phase set samples at end, clear at middle of bit
// - outside framed operation, edge bit set changes data active-to-idle, clear idle-to-active
// - polarity one gives idle-high clock, zero gives idle-low clock
// - slave-select enable makes the select pin gate slave operation
// - master enable makes the port drive the clock, else external clock
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
module scp_port (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic framed_operation_enable_in,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_out,
  input wire logic serial_data_in_pin_in,
  output logic serial_data_out_pin_out,
  output logic serial_data_out_pin_oe_out,
  input wire logic slave_select_pin_n_in
);

  ////////////////////////////////////////////////////////////////////////////////
  // state types

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] tx;
    logic [15:0] rx;
    logic busy;
    logic rxv;
    logic start_tog;
    logic done_seen;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } scp_bus_t;

  typedef enum logic {LK_IDLE, LK_RUN} scp_lstate_t;

  typedef struct packed {
    scp_lstate_t st;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic [15:0] rx_word;
    logic [5:0] edge_ix;
    logic [4:0] nsamp;
    logic [9:0] div;
    logic sck_lvl;
    logic start_seen;
    logic done_tog;
    logic sck_prev;
    logic sdo;
    logic sdo_oe;
    logic sck_oe;
  } scp_link_t;

  scp_bus_t bs_q;
  scp_bus_t bs_d;
  scp_link_t lk_q;
  scp_link_t lk_d;

  ////////////////////////////////////////////////////////////////////////////////
  // crossings between bus clock and link clock

  logic [14:0] cfg_s;
  logic [2:0] pins_s;
  logic done_s;

  // configuration levels and start toggle into the link domain
  scp_sync #(.WIDTH(15)) u_cfg_sync (
    .clk_in(link_clk_in),
    .rst_n_in(rst_n_in),
    .d_in({bs_q.start_tog, framed_operation_enable_in, bs_q.ctrl[scp_pkg::CFG_W-1:0]}),
    .q_out(cfg_s)
  );

  // pins into the link domain
  scp_sync #(.WIDTH(3)) u_pin_sync (
    .clk_in(link_clk_in),
    .rst_n_in(rst_n_in),
    .d_in({serial_clock_pin_in, serial_data_in_pin_in, slave_select_pin_n_in}),
    .q_out(pins_s)
  );

  // completion toggle back to the bus domain
  scp_sync #(.WIDTH(1)) u_done_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in(lk_q.done_tog),
    .q_out(done_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus side: register file as a zero-wait slave

  logic addr_take;
  logic [7:0] addr_lo;
  logic done_ev;
  logic rd_data_clr;

  assign addr_take = hsel_in && hready_in && (htrans_in == scp_pkg::HTRANS_NONSEQ);
  assign addr_lo = haddr_in[7:0];
  assign done_ev = (done_s != bs_q.done_seen);
  assign rd_data_clr = addr_take && !hwrite_in && (addr_lo == scp_pkg::OFF_DATA);

  // register access, start handshake, completion capture
  always_comb begin
    bs_d = bs_q;
    bs_d.wr_pend = addr_take && hwrite_in;
    if (addr_take) begin
      bs_d.wr_addr = addr_lo;
    end
    // read data captured at the address phase, unmapped reads zero
    if (addr_take && !hwrite_in) begin
      unique case (addr_lo)
        scp_pkg::OFF_CTRL1: bs_d.rdata = {16'h0000, bs_q.ctrl};
        scp_pkg::OFF_DATA: bs_d.rdata = {16'h0000, bs_q.rx};
        scp_pkg::OFF_STAT: bs_d.rdata = {30'h0000_0000, bs_q.rxv, bs_q.busy};
        default: bs_d.rdata = scp_pkg::RDATA_RST;
      endcase
    end
    // data phase of a write
    if (bs_q.wr_pend) begin
      if (bs_q.wr_addr == scp_pkg::OFF_CTRL1) begin
        bs_d.ctrl = hwdata_in[15:0] & scp_pkg::CTRL1_WMASK;
      end
      // a data write while a word is in flight is dropped
      if (bs_q.wr_addr == scp_pkg::OFF_DATA && !bs_q.busy) begin
        bs_d.tx = hwdata_in[15:0];
        bs_d.busy = 1'b1;
        bs_d.start_tog = !bs_q.start_tog;
      end
    end
    // reading the data word clears the flag, completion sets it and wins
    if (rd_data_clr) begin
      bs_d.rxv = 1'b0;
    end
    if (done_ev) begin
      bs_d.done_seen = done_s;
      bs_d.busy = 1'b0;
      bs_d.rx = lk_q.rx_word;
      bs_d.rxv = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bs_q <= '{ctrl: scp_pkg::CTRL1_RST, tx: scp_pkg::DATA_RST, rx: scp_pkg::DATA_RST,
                busy: 1'b0, rxv: 1'b0, start_tog: 1'b0, done_seen: 1'b0,
                wr_pend: 1'b0, wr_addr: 8'h00, rdata: scp_pkg::RDATA_RST};
    end else begin
      bs_q <= bs_d;
    end
  end

  assign hrdata_out = bs_q.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // link side: decoded configuration

  logic clk_dis, do_dis, wide, input_sample_phase, edge_bit, slave_select_enable, cpol, mst, framed, start_req;
  logic [1:0] pri_code;
  logic [2:0] sec_code;
  logic sck_s, sdi_s, ss_n_s, ss_ok;
  logic chg_par, smp_par, cke_eff;
  logic [4:0] nbits;
  logic [9:0] ratio, half1, half2;

  assign {start_req, framed} = {cfg_s[14] != lk_q.start_seen, cfg_s[13]};
  assign clk_dis = cfg_s[scp_pkg::B_CLK_DIS];
  assign do_dis = cfg_s[scp_pkg::B_DO_DIS];
  assign wide = cfg_s[scp_pkg::B_WIDTH];
  assign input_sample_phase = cfg_s[scp_pkg::B_SMP];
  assign edge_bit = cfg_s[scp_pkg::B_EDGE];
  assign slave_select_enable = cfg_s[scp_pkg::B_SLAVE_SELECT_ENABLE];
  assign cpol = cfg_s[scp_pkg::B_CPOL];
  assign mst = cfg_s[scp_pkg::B_MST];
  assign sec_code = cfg_s[scp_pkg::B_SEC_LSB +: 3];
  assign pri_code = cfg_s[scp_pkg::B_PRI_LSB +: 2];
  assign {sck_s, sdi_s, ss_n_s} = pins_s;
  assign nbits = wide ? scp_pkg::WORD_BITS : scp_pkg::BYTE_BITS;
  // edge setting ignored in framed operation
  assign cke_eff = edge_bit && !framed;
  // odd edges (active to idle) carry data changes when set
  assign chg_par = cke_eff;
  // master may sample on the change edge; slave samples mid-bit
  assign smp_par = (mst && input_sample_phase) ? chg_par : !chg_par;
  // select pin gates the slave only when enabled
  assign ss_ok = !slave_select_enable || !ss_n_s;
  // divide by primary times secondary ratio, split in two halves
  assign ratio = 10'(scp_pkg::primary_ratio(pri_code) * scp_pkg::secondary_ratio(sec_code));
  assign half1 = (ratio > 10'h001) ? (ratio >> 1) : 10'h001;
  assign half2 = (ratio > 10'h001) ? (ratio - half1) : 10'h001;

  ////////////////////////////////////////////////////////////////////////////////
  // link side: serial engine

  logic edge_ev, edge_par, do_smp, do_shift, finish;
  logic [15:0] rx_nx;

  always_comb begin
    lk_d = lk_q;
    // master edges advance only while the internal clock runs
    if (mst) begin
      edge_ev = (lk_q.st == LK_RUN) && !clk_dis && (lk_q.div == 10'h001);
      edge_par = lk_q.edge_ix[0];
    end else begin
      // slave edges come from the external clock pin
      edge_ev = (lk_q.st == LK_RUN) && ss_ok && (sck_s != lk_q.sck_prev);
      edge_par = (sck_s == cpol);
    end
    // sample edges; a sample at the very first edge only mid-bit
    do_smp = edge_ev && (edge_par == smp_par) && (lk_q.nsamp < nbits)
             && !((lk_q.edge_ix == 6'h00) && (smp_par == chg_par));
    // data changes on the chosen edge, first bit preloaded, none at the closing edge
    do_shift = edge_ev && (edge_par == chg_par) && (lk_q.edge_ix != 6'h00)
               && (lk_q.edge_ix != {nbits, 1'b0});
    rx_nx = do_smp ? {lk_q.rx_sh[14:0], sdi_s} : lk_q.rx_sh;
    if (mst) begin
      finish = edge_ev && (lk_q.edge_ix == {nbits, 1'b0});
    end else begin
      finish = do_smp && ((lk_q.nsamp + 5'h01) == nbits);
    end
    lk_d.sck_prev = sck_s;
    if (lk_q.st == LK_IDLE) begin
      // clock rests at the idle level chosen by polarity
      lk_d.sck_lvl = cpol;
      if (start_req) begin
        lk_d.start_seen = cfg_s[14];
        lk_d.st = LK_RUN;
        lk_d.tx_sh = bs_q.tx;
        lk_d.edge_ix = 6'h00;
        lk_d.nsamp = 5'h00;
        lk_d.div = half1;
      end
    end else begin
      if (mst && !clk_dis) begin
        lk_d.div = (lk_q.div == 10'h001) ? (lk_q.edge_ix[0] ? half1 : half2)
                                          : (lk_q.div - 10'h001);
      end
      if (edge_ev) begin
        lk_d.edge_ix = lk_q.edge_ix + 6'h01;
        if (mst && !finish) begin
          lk_d.sck_lvl = !lk_q.sck_lvl;
        end
      end
      if (do_smp) begin
        lk_d.rx_sh = rx_nx;
        lk_d.nsamp = lk_q.nsamp + 5'h01;
      end
      if (do_shift) begin
        lk_d.tx_sh = {lk_q.tx_sh[14:0], 1'b0};
      end
      // byte results keep the upper half zero
      if (finish) begin
        lk_d.st = LK_IDLE;
        lk_d.done_tog = !lk_q.done_tog;
        lk_d.rx_word = wide ? rx_nx : {8'h00, rx_nx[7:0]};
      end
      if (!mst && slave_select_enable && ss_n_s) begin
        lk_d.edge_ix = 6'h00;
        lk_d.nsamp = 5'h00;
        lk_d.tx_sh = bs_q.tx;
      end
    end
    lk_d.sdo = wide ? lk_d.tx_sh[15] : lk_d.tx_sh[7];
    lk_d.sdo_oe = !do_dis && (mst || ss_ok);
    // clock pin driven only by an enabled master
    lk_d.sck_oe = mst && !clk_dis;
  end

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lk_q <= '{st: LK_IDLE, tx_sh: 16'h0000, rx_sh: 16'h0000, rx_word: 16'h0000,
                edge_ix: 6'h00, nsamp: 5'h00, div: 10'h001, sck_lvl: 1'b0,
                start_seen: 1'b0, done_tog: 1'b0, sck_prev: 1'b0, sdo: 1'b0,
                sdo_oe: 1'b0, sck_oe: 1'b0};
    end else begin
      lk_q <= lk_d;
    end
  end

  assign serial_clock_pin_out = lk_q.sck_lvl;
  assign serial_clock_pin_oe_out = lk_q.sck_oe;
  assign serial_data_out_pin_out = lk_q.sdo;
  assign serial_data_out_pin_oe_out = lk_q.sdo_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_master_stalled;
    (lk_q.st == LK_RUN) && mst && clk_dis;
  endsequence
  sequence s_data_write_idle;
    bs_q.wr_pend && (bs_q.wr_addr == scp_pkg::OFF_DATA) && !bs_q.busy;
  endsequence

  a_bus_data_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_data_write_idle |=> bs_q.busy && (bs_q.start_tog != $past(bs_q.start_tog))
                          && (bs_q.tx == $past(hwdata_in[15:0])))
    else $error("data write did not start a transfer");
  a_ctrl_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (bs_q.wr_pend && (bs_q.wr_addr == scp_pkg::OFF_CTRL1))
    |=> bs_q.ctrl == ($past(hwdata_in[15:0]) & scp_pkg::CTRL1_WMASK))
    else $error("control write not stored");
  a_flag_set_wins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (done_ev && rd_data_clr) |=> bs_q.rxv && !bs_q.busy)
    else $error("completion lost against a read");
  a_clock_pin_release: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (mst && clk_dis) |=> !lk_q.sck_oe)
    else $error("clock pin still driven while disabled");
  a_clock_stopped: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    s_master_stalled |=> $stable(lk_q.sck_lvl) && $stable(lk_q.edge_ix))
    else $error("serial clock moved while disabled");
  a_data_pin_release: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    do_dis |=> !lk_q.sdo_oe)
    else $error("data-out pin driven while disabled");
  a_word_length: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (finish && $stable(wide)) |=> lk_q.nsamp == $past(nbits))
    else $error("transfer length differs from width select");
  a_change_edge: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    ($past(lk_q.st) == LK_RUN && mst && $past(do_shift) && $stable(cpol) && $stable(cke_eff))
    |-> ((lk_q.sck_lvl == cpol) == cke_eff))
    else $error("output changed on the wrong clock edge");
  a_idle_level: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    ((lk_q.st == LK_IDLE) && !start_req && $stable(cpol)) |=> lk_q.sck_lvl == $past(cpol))
    else $error("idle clock level wrong");
  a_slave_no_clock: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    !mst |=> !lk_q.sck_oe)
    else $error("slave drives the clock pin");
  a_select_gates: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (!mst && slave_select_enable && ss_n_s) |=> !lk_q.sdo_oe)
    else $error("deselected slave drives data out");

endmodule : scp_port

// [rtl/scp_sync.sv]
// two flip-flop level synchroniser, parameterised width
module scp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } scp_sync_t;

  scp_sync_t s_q;
  scp_sync_t s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d.meta = d_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.stable;

endmodule : scp_sync

// [verif/scp_peer.sv]
// serial partner model: listens to a master port or clocks a slave port
module scp_peer (
  input wire logic sck_in,
  input wire logic sck_oe_in,
  input wire logic sdo_in,
  input wire logic mst_in,
  input wire logic cpol_in,
  input wire logic edge_in,
  input wire logic [4:0] nbits_in,
  input wire logic arm_in,
  input wire logic sel_in,
  input wire logic [15:0] tx_in,
  output logic sck_out,
  output logic sdi_out,
  output logic ss_n_out,
  output logic [15:0] rx_out,
  output logic [4:0] lead_out,
  output logic [15:0] per_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic own_q = 1'b0;
  logic prev_q = 1'b0;
  logic bit_q = 1'b0;
  logic lead;
  int nsamp = 0;
  time t0 = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // pin levels: an undriven clock pin rests at the idle level
  assign sck_out = sck_oe_in ? sck_in : (mst_in ? cpol_in : own_q);
  // released data line shows the inverse of its last bit
  assign sdi_out = arm_in ? bit_q : ~bit_q;
  assign ss_n_out = ~(arm_in & sel_in);

  // arm: clear counters, preload first bit, clock a slave port if needed
  always @(posedge arm_in) begin
    rx_out = 16'h0000;
    lead_out = 5'h00;
    per_out = 16'h0000;
    nsamp = 0;
    bit_q = tx_in[nbits_in-1];
    own_q = cpol_in;
    if (!mst_in) begin
      #2000;
      repeat (2 * nbits_in) #1000 own_q = ~own_q;
    end
  end

  // edge tracking; ignored while a master port has let go of its clock pin
  always @(sck_out) begin
    if (arm_in && (!mst_in || sck_oe_in) && sck_out !== prev_q) begin
      lead = (sck_out !== cpol_in);
      if (lead) begin
        lead_out++;
        if (lead_out == 5'h01) t0 = $time;
        if (lead_out == 5'h02) per_out = 16'($time - t0);
      end
      // sample on one edge, move to the next bit on the other
      if (lead == edge_in) begin
        rx_out = {rx_out[14:0], sdo_in};
        nsamp++;
      end else if (nsamp < nbits_in) begin
        bit_q = tx_in[nbits_in-1-nsamp];
      end
    end
    if (!mst_in || sck_oe_in) prev_q = sck_out;
  end
endmodule : scp_peer

// [verif/scp_port_tb_top.sv]
// self-checking bench for the serial port control block
module scp_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h seen %h", nm, e, g); end end

  typedef struct packed {
    logic [15:0] ctrl;
    logic fr;
    logic [15:0] tx;
    logic [15:0] px;
  } scp_row_t;

  logic clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic framed = 1'b0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic sck_o, sck_oe, sdo, sdo_oe, sck_w, sdi, ss_n;
  logic mst = 1'b1, cpol = 1'b0, edg = 1'b0, arm = 1'b0, sel = 1'b1;
  logic [4:0] nb = 5'h08;
  logic [4:0] lead, l0;
  logic [15:0] ptx = 16'h0000;
  logic [15:0] prx, per;
  logic [31:0] q;
  int fails = 0;
  int n_tests = 0;
  // master rows keep prescalers off 1:1 together and select enable off when framed
  // legal settings
  scp_row_t rows [7] = '{
    '{16'h013A, 1'b0, 16'h00A5, 16'h003C}, '{16'h053A, 1'b0, 16'hC3A5, 16'h5A0F},
    '{16'h007A, 1'b0, 16'h0081, 16'h007E}, '{16'h073A, 1'b0, 16'h0F1E, 16'hF00D},
    '{16'h027A, 1'b0, 16'h006C, 16'h0093}, '{16'h0172, 1'b1, 16'h005A, 16'h00C3},
    '{16'h013C, 1'b0, 16'hFF01, 16'h1280}};

  ////////////////////////////////////////////////////////////////////////////////
  // bus clock and free unrelated link clock
  initial forever #50 clk_in = ~clk_in;
  initial begin
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  scp_port dut (.clk_in(clk_in), .rst_n_in(rst_n), .link_clk_in(link_clk), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .framed_operation_enable_in(framed), .serial_clock_pin_in(sck_w),
    .serial_clock_pin_out(sck_o), .serial_clock_pin_oe_out(sck_oe),
    .serial_data_in_pin_in(sdi), .serial_data_out_pin_out(sdo),
    .serial_data_out_pin_oe_out(sdo_oe), .slave_select_pin_n_in(ss_n));

  scp_peer peer (.sck_in(sck_o), .sck_oe_in(sck_oe), .sdo_in(sdo), .mst_in(mst),
    .cpol_in(cpol), .edge_in(edg), .nbits_in(nb), .arm_in(arm), .sel_in(sel), .tx_in(ptx),
    .sck_out(sck_w), .sdi_out(sdi), .ss_n_out(ss_n), .rx_out(prx), .lead_out(lead),
    .per_out(per));

  ////////////////////////////////////////////////////////////////////////////////
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq);
    @(posedge clk_in);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= scp_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    rq = hrdata;
  endtask : bus

  // poll status until the word in flight is done
  task automatic wait_idle();
    repeat (1000) begin
      bus(1'b0, scp_pkg::OFF_STAT, 32'h0, q);
      if (q[scp_pkg::B_STAT_BUSY] === 1'b0) return;
    end
    `CHK("idle wait", 1'b0, q[scp_pkg::B_STAT_BUSY])
  endtask : wait_idle

  // serial clock period in link cycles from the prescale fields
  function automatic int ratio(input logic [15:0] c);
    int p;
    p = (c[1:0] == 2'h3) ? 1 : (c[1:0] == 2'h2) ? 4 : (c[1:0] == 2'h1) ? 16 : 64;
    return p * (8 - c[4:2]);
  endfunction : ratio

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // watchdog well beyond the expected run
  initial begin
    #3000000;
    fails++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n <= 1'b1;
    // master transfers from the table
    foreach (rows[i]) begin
      cpol <= rows[i].ctrl[6];
      edg <= rows[i].ctrl[8] & ~rows[i].fr;
      nb <= rows[i].ctrl[10] ? 5'h10 : 5'h08;
      ptx <= rows[i].px;
      framed <= rows[i].fr;
      bus(1'b1, scp_pkg::OFF_CTRL1, {16'h0000, rows[i].ctrl}, q);
      repeat (10) @(posedge clk_in);
      `CHK("idle clock", rows[i].ctrl[6], sck_o)
      `CHK("clock drive", 1'b1, sck_oe)
      arm <= 1'b1;
      bus(1'b1, scp_pkg::OFF_DATA, {16'h0000, rows[i].tx}, q);
      wait_idle();
      bus(1'b0, scp_pkg::OFF_DATA, 32'h0, q);
      `CHK("rx word", {16'h0, rows[i].ctrl[10] ? rows[i].px : {8'h0, rows[i].px[7:0]}}, q)
      `CHK("peer rx", rows[i].ctrl[10] ? rows[i].tx : {8'h0, rows[i].tx[7:0]}, prx)
      `CHK("bit count", nb, lead)
      `CHK("period", 16'(ratio(rows[i].ctrl) * 125), per)
      arm <= 1'b0;
    end
    framed <= 1'b0;
    // clock pin disabled in mid word stalls the clock, clearing it resumes
    cpol <= 1'b0;
    edg <= 1'b1;
    nb <= 5'h10;
    ptx <= 16'h1357;
    bus(1'b1, scp_pkg::OFF_CTRL1, 32'h0000_053A, q);
    arm <= 1'b1;
    bus(1'b1, scp_pkg::OFF_DATA, 32'h0000_BEEF, q);
    repeat (40) @(posedge clk_in);
    bus(1'b1, scp_pkg::OFF_CTRL1, 32'h0000_153A, q);
    repeat (5) @(posedge clk_in);
    `CHK("clock released", 1'b0, sck_oe)
    l0 = lead;
    repeat (50) @(posedge clk_in);
    `CHK("clock frozen", l0, lead)
    bus(1'b1, scp_pkg::OFF_CTRL1, 32'h0000_053A, q);
    wait_idle();
    `CHK("resumed word", 16'hBEEF, prx)
    arm <= 1'b0;
    // slave with select in use; sample phase kept zero
    // sample phase zero
    mst <= 1'b0;
    nb <= 5'h08;
    ptx <= 16'h00C6;
    bus(1'b1, scp_pkg::OFF_CTRL1, 32'h0000_0180, q);
    repeat (10) @(posedge clk_in);
    `CHK("slave clock", 1'b0, sck_oe)
    `CHK("deselected data", 1'b0, sdo_oe)
    bus(1'b1, scp_pkg::OFF_DATA, 32'h0000_0035, q);
    arm <= 1'b1;
    wait_idle();
    bus(1'b0, scp_pkg::OFF_DATA, 32'h0, q);
    `CHK("data drive", 1'b1, sdo_oe)
    `CHK("slave rx", 32'h0000_00C6, q)
    `CHK("slave tx", 16'h0035, prx)
    arm <= 1'b0;
    // select high gates the frame, then select ignored once disabled
    sel <= 1'b0;
    ptx <= 16'h0077;
    bus(1'b1, scp_pkg::OFF_DATA, 32'h0000_0011, q);
    arm <= 1'b1;
    repeat (220) @(posedge clk_in);
    bus(1'b0, scp_pkg::OFF_STAT, 32'h0, q);
    `CHK("gated busy", 1'b1, q[scp_pkg::B_STAT_BUSY])
    arm <= 1'b0;
    bus(1'b1, scp_pkg::OFF_CTRL1, 32'h0000_0100, q);
    arm <= 1'b1;
    wait_idle();
    bus(1'b0, scp_pkg::OFF_DATA, 32'h0, q);
    `CHK("select ignored", 32'h0000_0077, q)
    `CHK("select ignored tx", 16'h0011, prx)
    arm <= 1'b0;
    // second reset in mid run, then reset values and access kinds
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_in);
    `CHK("reset clock oe", 1'b0, sck_oe)
    `CHK("reset data oe", 1'b0, sdo_oe)
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_in);
    `CHK("data pin driven", 1'b1, sdo_oe)
    bus(1'b0, scp_pkg::OFF_CTRL1, 32'h0, q);
    `CHK("ctrl reset", 32'h0000_0000, q)
    bus(1'b0, scp_pkg::OFF_STAT, 32'h0, q);
    `CHK("status reset", 32'h0000_0000, q)
    bus(1'b0, scp_pkg::OFF_DATA, 32'h0, q);
    `CHK("data reset", 32'h0000_0000, q)
    bus(1'b1, scp_pkg::OFF_CTRL1, 32'hFFFF_FFFB, q);
    bus(1'b0, scp_pkg::OFF_CTRL1, 32'h0, q);
    `CHK("ctrl mask", 32'h0000_1FFB, q)
    repeat (10) @(posedge clk_in);
    `CHK("data pin released", 1'b0, sdo_oe)
    `CHK("clock pin released", 1'b0, sck_oe)
    bus(1'b0, 8'h0C, 32'h0, q);
    `CHK("unmapped read", 32'h0000_0000, q)
    `CHK("response okay", 1'b0, hresp)
    `CHK("ready high", 1'b1, hready)
    complete_run();
  end
endmodule : scp_port_tb_top
